// file: core/deac_consts.vh
// Purpose: Constants for the data EEPROM access control block.
// Assumes: Instruction clock of 100 MHz.
// Notes:   Register selects are the index on the special function port.
`ifndef DEAC_CONSTS_VH
`define DEAC_CONSTS_VH

// Clock
`define DEAC_CLK_PERIOD_NS   10

// Register selects on the special function port
`define DEAC_SEL_CTRL        3'h0
`define DEAC_SEL_KEY         3'h1
`define DEAC_SEL_DATA        3'h2
`define DEAC_SEL_ADDR_LO     3'h3
`define DEAC_SEL_ADDR_HI     3'h4

// Control register bit positions
`define DEAC_B_PGD           7
`define DEAC_B_CONFIG_SPACE_SELECT          6
`define DEAC_B_FREE          4
`define DEAC_B_ERR           3
`define DEAC_B_MODIFY_PERMIT          2
`define DEAC_B_WR            1
`define DEAC_B_RD            0

// Reset values
`define DEAC_RST_BYTE        8'h00
`define DEAC_RST_HI          2'h0

// Unlock key bytes
`define DEAC_KEY_FIRST       8'h55
`define DEAC_KEY_SECOND      8'haa

// Self-timed phases, in microseconds (plain defaults)
`define DEAC_ERASE_US        1000
`define DEAC_PROG_US         1000

`endif

// file: core/deac_ctrl.v
// Purpose: Access control for a 1024-byte data EEPROM behind special
//          function registers: address pair, data, control, unlock key.
// Assumes: Core strobes sfr_wr or sfr_rd for one clock per access; the
//          array answers nv_rdata combinationally from nv_addr.
// Notes:   Data space writes are self-timed erase then program, counted in clocks.
//          The power-up timer input is synchronised before any use; it
//          resets to busy so no launch slips through before it settles.
//
// How it works
// - One byte moved per read or write
// - High address keeps two bits, 10-bit range
// - Byte write erases, then programs, both timed
// - Program select set routes to program memory
// - Config select set routes to configuration space
// - Modify permit gates writes, clear at power-up
// - Abort flag on reset mid-write or misuse
// - Abort keeps both space selects untouched
// - Launch bit set-only, cleared at write end
// - Write end sets done flag, software clears
// - Fetch bit set-only, refused outside data space
// - Read completes in one cycle
// - Data register holds last read or write
// - Unlock key stores nothing, reads zero
// - Row clear makes a program-space launch erase row
// - Control bit five reads zero
// - Launch needs 55h, then AAh, then launch
// - Permit must already be set before launch
// - Registers locked while write runs
// - Writes blocked during power-up timer
`include "deac_consts.vh"

module deac_ctrl #(
  parameter ERASE_CYCLES = (`DEAC_ERASE_US * 1000 + `DEAC_CLK_PERIOD_NS - 1)
                           / `DEAC_CLK_PERIOD_NS,
  parameter PROG_CYCLES  = (`DEAC_PROG_US * 1000 + `DEAC_CLK_PERIOD_NS - 1)
                           / `DEAC_CLK_PERIOD_NS
) (
  // Clock and resets
  input  wire       clk,
  input  wire       rst_b,
  input  wire       warm_rst,
  input  wire       pwrt_busy,
  // Special function register port
  input  wire [2:0] sfr_sel,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  input  wire [7:0] sfr_wdata,
  output wire [7:0] sfr_rdata,
  // Data EEPROM array
  output wire [9:0] nv_addr,
  output wire [7:0] nv_wdata,
  output wire       nv_rd,
  input  wire [7:0] nv_rdata,
  output wire       nv_erase,
  output wire       nv_prog,
  // Program memory and configuration side
  output wire       program_space_select,
  output wire       config_space_select,
  output wire       pm_row_erase,
  output wire       pm_prog,
  // Write done flag of periph_flag_reg2
  output wire       nv_write_done_flag,
  input  wire       done_flag_clr
);

  //////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE  = 2'h0;
  localparam ST_ERASE = 2'h1;
  localparam ST_PROG  = 2'h2;

  localparam KEY_NONE = 2'h0;
  localparam KEY_ONE  = 2'h1;
  localparam KEY_TWO  = 2'h2;

  localparam [19:0] ERASE_LEN = ERASE_CYCLES[19:0];
  localparam [19:0] PROG_LEN  = PROG_CYCLES[19:0];

  // Phase length for the self-timed counter
  function [19:0] phase_len;
    input erase;
    begin
      phase_len = erase ? ERASE_LEN : PROG_LEN;
    end
  endfunction

  // Register select decode, shared by the write strobes
  function sel_hit;
    input [2:0] sel;
    input [2:0] want;
    begin
      sel_hit = (sel == want);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  reg  [7:0]  data_r;
  reg  [7:0]  addr_lo_r;
  reg  [1:0]  addr_hi_r;
  reg         pgd_r;
  reg         config_space_select_r;
  reg         free_r;
  reg         err_r;
  reg         modify_permit_r;
  reg         wr_r;
  reg         rd_r;
  reg  [1:0]  key_r;
  reg  [1:0]  st_r;
  reg  [19:0] cnt_r;
  reg  [7:0]  rdata_r;
  reg         done_r;
  reg         pwrt_meta_r;
  reg         pwrt_sync_r;

  wire        busy;
  wire        data_sp;
  wire        wr_ctrl;
  wire        wr_key;
  wire        launch_rq;
  wire        launch_ok;
  wire        launch;
  wire        launch_bad;
  wire        fetch_ok;
  wire        last_tick;
  wire        erase_end;
  wire        prog_end;
  wire        erase_sel;
  wire        done_ev;
  wire [7:0]  ctrl_view;

  //////////////////////////////////////////////////////////////////////////
  // Request decode
  assign busy       = (st_r != ST_IDLE);
  assign data_sp    = ~pgd_r & ~config_space_select_r;
  assign wr_ctrl    = sfr_wr & sel_hit(sfr_sel, `DEAC_SEL_CTRL);
  assign wr_key     = sfr_wr & sel_hit(sfr_sel, `DEAC_SEL_KEY);
  assign launch_rq  = wr_ctrl & ~busy & sfr_wdata[`DEAC_B_WR];
  // Permit is the stored value, so permit and launch in one write fail
  assign launch_ok  = (key_r == KEY_TWO) & modify_permit_r
                      & ~pwrt_sync_r;
  assign launch     = launch_rq & launch_ok;
  assign launch_bad = launch_rq & ~launch_ok;
  assign fetch_ok   = sfr_wdata[`DEAC_B_RD] & ~launch_rq
                      & ~sfr_wdata[`DEAC_B_PGD] & ~sfr_wdata[`DEAC_B_CONFIG_SPACE_SELECT];
  // Counter runs down to one, so a phase end is a single compare
  assign last_tick  = (cnt_r == 20'h00001);
  assign erase_end  = (st_r == ST_ERASE) & last_tick;
  assign prog_end   = (st_r == ST_PROG) & last_tick;
  assign erase_sel  = sfr_wdata[`DEAC_B_CONFIG_SPACE_SELECT] ? 1'b0
                    : sfr_wdata[`DEAC_B_PGD] ? sfr_wdata[`DEAC_B_FREE]
                    : 1'b1;
  assign done_ev    = prog_end | (erase_end & ~data_sp);
  assign ctrl_view  = {pgd_r, config_space_select_r, 1'b0, free_r,
                       err_r, modify_permit_r, wr_r, rd_r};

  //////////////////////////////////////////////////////////////////////////
  // The power-up timer runs from its own oscillator; two cycles of lag
  // only delay the first permitted launch
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwrt_meta_r <= 1'b1;
      pwrt_sync_r <= 1'b1;
    end else begin
      pwrt_meta_r <= pwrt_busy;
      pwrt_sync_r <= pwrt_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Unlock sequence tracker; any other register write breaks it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      key_r <= KEY_NONE;
    end else if (warm_rst) begin
      key_r <= KEY_NONE;
    end else if (wr_key) begin
      if (sfr_wdata == `DEAC_KEY_FIRST) begin
        key_r <= KEY_ONE;
      end else if (sfr_wdata == `DEAC_KEY_SECOND && key_r == KEY_ONE) begin
        key_r <= KEY_TWO;
      end else begin
        key_r <= KEY_NONE;
      end
    end else if (sfr_wr) begin
      key_r <= KEY_NONE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control, address, data and the self-timed write sequencer
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_r    <= `DEAC_RST_BYTE;
      addr_lo_r <= `DEAC_RST_BYTE;
      addr_hi_r <= `DEAC_RST_HI;
      pgd_r     <= 1'b0;
      config_space_select_r    <= 1'b0;
      free_r    <= 1'b0;
      err_r     <= 1'b0;
      modify_permit_r    <= 1'b0;
      wr_r      <= 1'b0;
      rd_r      <= 1'b0;
      st_r      <= ST_IDLE;
      cnt_r     <= 20'h00000;
    end else if (warm_rst) begin
      // Space selects survive so the failed access can be traced
      if (busy) begin
        err_r <= 1'b1;
      end
      free_r <= 1'b0;
      modify_permit_r <= 1'b0;
      wr_r   <= 1'b0;
      rd_r   <= 1'b0;
      st_r   <= ST_IDLE;
      cnt_r  <= 20'h00000;
    end else begin
      rd_r <= 1'b0;
      if (rd_r) begin
        data_r <= nv_rdata;
      end
      case (st_r)
        ST_IDLE: begin
          if (launch) begin
            wr_r  <= 1'b1;
            err_r <= 1'b0;
            st_r  <= erase_sel ? ST_ERASE : ST_PROG;
            cnt_r <= phase_len(erase_sel);
          end
        end
        ST_ERASE: begin
          if (last_tick) begin
            // A data byte always goes on to programming after its erase
            if (data_sp) begin
              st_r  <= ST_PROG;
              cnt_r <= phase_len(1'b0);
            end else begin
              free_r <= 1'b0;
              wr_r   <= 1'b0;
              st_r   <= ST_IDLE;
              cnt_r  <= 20'h00000;
            end
          end else begin
            cnt_r <= cnt_r - 20'h00001;
          end
        end
        ST_PROG: begin
          if (last_tick) begin
            wr_r  <= 1'b0;
            st_r  <= ST_IDLE;
            cnt_r <= 20'h00000;
          end else begin
            cnt_r <= cnt_r - 20'h00001;
          end
        end
        default: begin
          st_r  <= ST_IDLE;
          cnt_r <= 20'h00000;
        end
      endcase
      // Register writes are refused while a write runs
      if (sfr_wr && !busy) begin
        case (sfr_sel)
          `DEAC_SEL_CTRL: begin
            pgd_r  <= sfr_wdata[`DEAC_B_PGD];
            config_space_select_r <= sfr_wdata[`DEAC_B_CONFIG_SPACE_SELECT];
            free_r <= sfr_wdata[`DEAC_B_FREE];
            modify_permit_r <= sfr_wdata[`DEAC_B_MODIFY_PERMIT];
            // Bit 3 follows the write only when no launch is asked
            if (launch_bad) begin
              err_r <= 1'b1;
            end else if (!launch) begin
              err_r <= sfr_wdata[`DEAC_B_ERR];
            end
            if (fetch_ok) begin
              rd_r <= 1'b1;
            end
          end
          `DEAC_SEL_DATA: begin
            data_r <= sfr_wdata;
          end
          `DEAC_SEL_ADDR_LO: begin
            addr_lo_r <= sfr_wdata;
          end
          `DEAC_SEL_ADDR_HI: begin
            addr_hi_r <= sfr_wdata[1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Completion flag: a completion in the clear cycle is kept
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_r <= 1'b0;
    end else if (done_ev && !warm_rst) begin
      done_r <= 1'b1;
    end else if (done_flag_clr) begin
      done_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read view of the register selected for a core read
  function [7:0] read_view;
    input [2:0] sel;
    begin
      case (sel)
        `DEAC_SEL_CTRL:    read_view = ctrl_view;
        `DEAC_SEL_KEY:     read_view = 8'h00;
        `DEAC_SEL_DATA:    read_view = data_r;
        `DEAC_SEL_ADDR_LO: read_view = addr_lo_r;
        `DEAC_SEL_ADDR_HI: read_view = {6'h00, addr_hi_r};
        default:           read_view = 8'h00;
      endcase
    end
  endfunction

  // Registered read data, valid the cycle after sfr_rd
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= `DEAC_RST_BYTE;
    end else if (sfr_rd) begin
      rdata_r <= read_view(sfr_sel);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign sfr_rdata            = rdata_r;
  assign nv_addr              = {addr_hi_r, addr_lo_r};
  assign nv_wdata             = data_r;
  assign nv_rd                = rd_r;
  // Array strobes are levels decoded from the live state
  assign nv_erase             = (st_r == ST_ERASE) & data_sp;
  assign nv_prog              = (st_r == ST_PROG) & data_sp;
  assign pm_row_erase         = (st_r == ST_ERASE) & ~data_sp;
  assign pm_prog              = (st_r == ST_PROG) & ~data_sp;
  assign program_space_select = pgd_r;
  assign config_space_select  = config_space_select_r;
  assign nv_write_done_flag   = done_r;

endmodule

// file: tb/deac_nv_model.sv
// Purpose: Behavioural data EEPROM array behind the access controller.
// Assumes: Erase and program levels last whole clock cycles.
// Notes:   Seeded contents depend on all ten address bits.
module deac_nv_model (
  // Array port
  input  wire       clk,
  input  wire [9:0] nv_addr,
  input  wire [7:0] nv_wdata,
  input  wire       nv_erase,
  input  wire       nv_prog,
  output wire [7:0] nv_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:1023];
  initial
    foreach (mem[i])
      mem[i] = 8'(i ^ (i >> 2));
  // Programming only clears bits, so a skipped erase shows up on read
  always @(posedge clk) begin
    if (nv_erase)
      mem[nv_addr] <= 8'hff;
    else if (nv_prog)
      mem[nv_addr] <= mem[nv_addr] & nv_wdata;
  end
  assign nv_rdata = mem[nv_addr];
endmodule

// file: tb/deac_ctrl_monitor.sv
// Purpose: Port-level checker for the EEPROM access control block.
// Assumes: Counts match the instance parameters.
// Notes:   Attached by bind at the foot of this file.
`include "deac_consts.vh"
module deac_ctrl_monitor #(
  parameter int ERASE_CYCLES = 4,
  parameter int PROG_CYCLES  = 4
) (
  // Clock and resets
  input wire       clk,
  input wire       rst_b,
  input wire       warm_rst,
  input wire       pwrt_busy,
  // Register port
  input wire [2:0] sfr_sel,
  input wire       sfr_wr,
  input wire       sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  // Array and flags
  input wire [9:0] nv_addr,
  input wire [7:0] nv_wdata,
  input wire       nv_rd,
  input wire       nv_erase,
  input wire       nv_prog,
  input wire       program_space_select,
  input wire       config_space_select,
  input wire       nv_write_done_flag,
  input wire       done_flag_clr
);
  logic [31:0] ecnt_r;
  logic [31:0] pcnt_r;
  // Phase lengths, so a count slip shows at the phase end
  always @(posedge clk) begin
    ecnt_r <= nv_erase ? ecnt_r + 32'h1 : 32'h0;
    pcnt_r <= nv_prog ? pcnt_r + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_erase_then_prog: assert property ($fell(nv_erase) && !$past(warm_rst)
    |-> ecnt_r == ERASE_CYCLES && nv_prog) else $error("erase phase");
  chk_prog_then_done: assert property ($fell(nv_prog) && !$past(warm_rst)
    |-> pcnt_r == PROG_CYCLES && nv_write_done_flag) else $error("prog");
  chk_flag_held: assert property (nv_write_done_flag && !done_flag_clr
    |=> nv_write_done_flag) else $error("done flag lost");
  chk_fetch_one_cycle: assert property (sfr_wr && sfr_wdata[0] &&
    sfr_sel == `DEAC_SEL_CTRL && sfr_wdata[7:6] == 2'h0 && !sfr_wdata[1] &&
    !nv_erase &&
    !nv_prog && !warm_rst |=> nv_rd) else $error("no fetch");
  chk_fetch_cause: assert property (nv_rd |-> $past(sfr_wr && sfr_wdata[0]
    && sfr_sel == `DEAC_SEL_CTRL)) else $error("stray fetch");
  chk_lock_busy: assert property (nv_erase || nv_prog |=> $stable(nv_addr)
    && $stable(nv_wdata)) else $error("changed while busy");
  chk_pwrt_block: assert property ($rose(nv_erase) |-> !$past(pwrt_busy, 3))
    else $error("write during power-up");
  chk_key_zero: assert property (sfr_rd && sfr_sel == `DEAC_SEL_KEY
    |=> sfr_rdata == 8'h00) else $error("key not zero");
  chk_sel_kept: assert property (warm_rst && !sfr_wr |=>
    $stable(program_space_select) && $stable(config_space_select))
    else $error("selects lost");
endmodule
bind deac_ctrl deac_ctrl_monitor #(.ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES(PROG_CYCLES)) u_mon (.*);

// file: tb/tb_data_eeprom_access_control.sv
// Purpose: Self-checking bench for the EEPROM access control block.
// Assumes: Short phase counts; array model on the far side.
// Notes:   Inputs change on the falling edge of clk.
`include "deac_consts.vh"
module tb_data_eeprom_access_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] CT = `DEAC_SEL_CTRL, KY = `DEAC_SEL_KEY;
  localparam logic [2:0] DT = `DEAC_SEL_DATA, AL = `DEAC_SEL_ADDR_LO;
  localparam logic [2:0] AH = `DEAC_SEL_ADDR_HI;
  logic clk = 0, rst_b = 0, warm_rst = 0, pwrt_busy = 0;
  logic sfr_wr = 0, sfr_rd = 0, done_flag_clr = 0;
  logic [2:0] sfr_sel = 3'h0;
  logic [7:0] sfr_wdata = 8'h00, sfr_rdata, nv_rdata, nv_wdata, v;
  logic [9:0] nv_addr;
  logic nv_rd, nv_erase, nv_prog, program_space_select;
  logic config_space_select, pm_row_erase, pm_prog, nv_write_done_flag;
  int num_errors = 0, tests_run = 0;
  deac_ctrl #(.ERASE_CYCLES(4), .PROG_CYCLES(6)) u_dut (.*);
  deac_nv_model u_nv (.*);
  initial
    forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    sfr_sel = s;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [2:0] s);
    sfr_sel = s;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    v = sfr_rdata;
    @(negedge clk);
  endtask
  task automatic launch(input logic [7:0] c);
    wr(KY, `DEAC_KEY_FIRST);
    wr(KY, `DEAC_KEY_SECOND);
    wr(CT, c);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_read;
    rd(CT);
    chk(v, 8'h00);
    rd(KY);
    chk(v, 8'h00);
    wr(AH, 8'hff);
    wr(AL, 8'h34);
    rd(AH);
    chk(v, 8'h03);
    wr(CT, 8'h01);
    @(negedge clk);
    rd(DT);
    chk(v, 8'hf9);
    rd(CT);
    chk(v, 8'h00);
    wr(AL, 8'h35);
    wr(CT, 8'h81);
    chk({7'h0, program_space_select}, 8'h01);
    wr(CT, 8'h41);
    chk({7'h0, config_space_select}, 8'h01);
    rd(CT);
    chk(v, 8'h40);
    rd(DT);
    chk(v, 8'hf9);
    $display("t_read done");
  endtask
  task automatic t_write;
    wr(DT, 8'ha5);
    wr(CT, 8'h04);
    launch(8'h06);
    chk({7'h0, nv_erase}, 8'h01);
    wr(DT, 8'h11);
    wr(CT, 8'h04);
    rd(CT);
    chk(v, 8'h06);
    for (int i = 0; i < 40 && nv_write_done_flag !== 1'b1; i++)
      @(negedge clk);
    chk({7'h0, nv_write_done_flag}, 8'h01);
    rd(CT);
    chk(v, 8'h04);
    wr(DT, 8'h00);
    wr(CT, 8'h05);
    @(negedge clk);
    rd(DT);
    chk(v, 8'ha5);
    done_flag_clr = 1'b1;
    @(negedge clk);
    done_flag_clr = 1'b0;
    chk({7'h0, nv_write_done_flag}, 8'h00);
    $display("t_write done");
  endtask
  // Broken key, permit set with launch, power-up timer running
  task automatic t_refuse;
    for (int i = 0; i < 3; i++) begin
      wr(CT, i == 1 ? 8'h00 : 8'h04);
      pwrt_busy = (i == 2);
      wr(KY, 8'h55);
      wr(KY, i == 0 ? 8'h00 : 8'haa);
      wr(CT, 8'h06);
      rd(CT);
      chk(v & 8'h0a, 8'h08);
      pwrt_busy = 1'b0;
    end
    $display("t_refuse done");
  endtask
  task automatic t_abort;
    wr(CT, 8'h84);
    launch(8'h86);
    @(negedge clk);
    warm_rst = 1'b1;
    @(negedge clk);
    warm_rst = 1'b0;
    rd(CT);
    chk(v, 8'h88);
    chk({7'h0, program_space_select}, 8'h01);
    $display("t_abort done");
  endtask
  // Program space row erase, then configuration space programming
  task automatic t_space;
    wr(CT, 8'h94);
    launch(8'h96);
    chk({6'h0, pm_row_erase, pm_prog}, 8'h02);
    chk({6'h0, nv_erase, nv_prog}, 8'h00);
    for (int i = 0; i < 40 && nv_write_done_flag !== 1'b1; i++)
      @(negedge clk);
    chk({7'h0, nv_write_done_flag}, 8'h01);
    rd(CT);
    chk(v, 8'h84);
    done_flag_clr = 1'b1;
    @(negedge clk);
    done_flag_clr = 1'b0;
    wr(CT, 8'h44);
    launch(8'h46);
    chk({6'h0, pm_row_erase, pm_prog}, 8'h01);
    for (int i = 0; i < 40 && nv_write_done_flag !== 1'b1; i++)
      @(negedge clk);
    chk({7'h0, nv_write_done_flag}, 8'h01);
    rd(CT);
    chk(v, 8'h44);
    $display("t_space done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_read();
    t_write();
    t_refuse();
    t_abort();
    t_space();
    stop_test();
  end
  initial begin
    #50us;
    num_errors++;
    $display("ERROR %0t: run hung", $time);
    stop_test();
  end
endmodule
